//--- include/ecp_params.svh
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH

// byte addresses of the two parameter words
`define ECP_STRUCT_OFFSET 18'h0_0004
`define ECP_CAP_OFFSET 18'h0_0008

// structural parameters fields
`define ECP_NPORTS_MSB 3
`define ECP_NPORTS_LSB 0
`define ECP_NPORTS_VAL 4'h1
`define ECP_PPC_BIT 4
`define ECP_PPC_VAL 1'h1
`define ECP_SRSVD_LO_MSB 6
`define ECP_SRSVD_LO_LSB 5
`define ECP_SRSVD_LO_VAL 2'h0
`define ECP_PRR_BIT 7
`define ECP_PRR_VAL 1'h0
`define ECP_NPCC_MSB 11
`define ECP_NPCC_LSB 8
`define ECP_NPCC_VAL 4'h0
`define ECP_NCC_MSB 15
`define ECP_NCC_LSB 12
`define ECP_NCC_VAL 4'h0
`define ECP_PIND_BIT 16
`define ECP_PIND_VAL 1'h0
`define ECP_SRSVD_MID_MSB 19
`define ECP_SRSVD_MID_LSB 17
`define ECP_SRSVD_MID_VAL 3'h0
`define ECP_DPN_MSB 23
`define ECP_DPN_LSB 20
`define ECP_DPN_VAL 4'h0
`define ECP_SRSVD_HI_MSB 31
`define ECP_SRSVD_HI_LSB 24
`define ECP_SRSVD_HI_VAL 8'h00

// capability parameters fields
`define ECP_CRSVD_B0_BIT 0
`define ECP_CRSVD_B0_VAL 1'h0
`define ECP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT 1
`define ECP_PROGRAMMABLE_FRAME_LIST_FLAG_VAL 1'h1
`define ECP_ASYNC_PARK_CAPABILITY_BIT 2
`define ECP_ASYNC_PARK_CAPABILITY_VAL 1'h1
`define ECP_CRSVD_B3_BIT 3
`define ECP_CRSVD_B3_VAL 1'h0
`define ECP_IST_MSB 7
`define ECP_IST_LSB 4
`define ECP_IST_VAL 4'h8
`define ECP_EECP_MSB 15
`define ECP_EECP_LSB 8
`define ECP_EECP_VAL 8'h00
`define ECP_CRSVD_HI_MSB 31
`define ECP_CRSVD_HI_LSB 16
`define ECP_CRSVD_HI_VAL 16'h0000

`define ECP_STRUCT_WORD {`ECP_SRSVD_HI_VAL, `ECP_DPN_VAL, `ECP_SRSVD_MID_VAL, `ECP_PIND_VAL, \
	`ECP_NCC_VAL, `ECP_NPCC_VAL, `ECP_PRR_VAL, `ECP_SRSVD_LO_VAL, `ECP_PPC_VAL, `ECP_NPORTS_VAL}
`define ECP_CAP_WORD {`ECP_CRSVD_HI_VAL, `ECP_EECP_VAL, `ECP_IST_VAL, `ECP_CRSVD_B3_VAL, \
	`ECP_ASYNC_PARK_CAPABILITY_VAL, `ECP_PROGRAMMABLE_FRAME_LIST_FLAG_VAL, `ECP_CRSVD_B0_VAL}

`define ECP_WORD_ZERO 32'h0000_0000

`endif

//--- include/ecp_pkg.sv
`default_nettype none
package ecp_pkg;
	typedef enum logic [2:0] {
		ECP_IDLE = 3'h1,
		ECP_READ = 3'h2,
		ECP_WRITE = 3'h4
	} ecp_state_type;

	typedef logic [31:0] ecp_word_type;
endpackage
`default_nettype wire

//--- rtl/ecp_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage pin filter, level moves once stages two and three agree
module ecp_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] lvl_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_q <= IDLE_VAL;
			s2_q <= IDLE_VAL;
			s3_q <= IDLE_VAL;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lvl_q <= IDLE_VAL;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					lvl_q[i] <= s2_q[i];
				end
			end
		end
	end

	assign level = lvl_q;
endmodule
`default_nettype wire

//--- rtl/ecp_param_rom.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecp_params.svh"
// fixed word lookup, write path has no storage at all
module ecp_param_rom (
	input wire logic [17:0] byte_addr,
	output logic hit,
	output ecp_pkg::ecp_word_type word
);
	function automatic logic [32:0] ecp_lookup(input logic [17:0] a);
		logic [32:0] r;
		r = {1'h0, `ECP_WORD_ZERO};
		if (a == `ECP_STRUCT_OFFSET) begin
			r = {1'h1, `ECP_STRUCT_WORD};
		end else if (a == `ECP_CAP_OFFSET) begin
			r = {1'h1, `ECP_CAP_WORD};
		end
		return r;
	endfunction

	always_comb begin
		{hit, word} = ecp_lookup(byte_addr);
	end
endmodule
`default_nettype wire

//--- rtl/ecp_capability_params.sv
`timescale 1ns/100ps
`default_nettype none
`include "ecp_params.svh"
// What this block does
// - structural parameters word is 32 bits, readable, never changed by software
// - port count field reads one downstream port
// - port power control support bit reads one
// - companion count and ports per companion both read zero
// - port routing method bit reads zero
// - debug port number field reads zero
// - port indicator bit reads zero
// - reserved bits read zero; software writes zero there
// - capability parameters word is 32 bits, readable, never writable
// - extended capability pointer reads zero, no capability list
// - isochronous scheduling threshold reads binary 1000
// - async park capability bit reads one
// - programmable frame list flag reads one
// - flag tells command register frame list size field to accept smaller lists
module ecp_capability_params (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [17:1] addr,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic data_oe,
	output logic [31:0] structural_parameters,
	output logic [31:0] capability_parameters,
	output logic programmable_frame_list_flag
);
	ecp_pkg::ecp_state_type state_q;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic [2:0] strobe_s;
	logic rom_hit;
	ecp_pkg::ecp_word_type rom_word;
	ecp_pkg::ecp_word_type rdata_q;
	logic hit_q;
	ecp_pkg::ecp_word_type struct_q;
	ecp_pkg::ecp_word_type cap_q;
	logic programmable_frame_list_flag_q;
	logic sel_rd;
	logic sel_wr;

	// strobes are pins from the processor side
	ecp_pin_sync #(
		.WIDTH(3),
		.IDLE_VAL(3'h7)
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.pin({cs_n, rd_n, wr_n}),
		.level(strobe_s)
	);
	assign {cs_n_s, rd_n_s, wr_n_s} = strobe_s;

	// address is stable well before the filtered strobe shows
	ecp_param_rom u_rom (
		.byte_addr({addr, 1'h0}),
		.hit(rom_hit),
		.word(rom_word)
	);

	assign sel_rd = !cs_n_s && !rd_n_s;
	assign sel_wr = !cs_n_s && !wr_n_s;

	// bus cycle tracking; read wins if both strobes low
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= ecp_pkg::ECP_IDLE;
		end else begin
			unique case (state_q)
				ecp_pkg::ECP_IDLE: begin
					if (sel_rd) begin
						state_q <= ecp_pkg::ECP_READ;
					end else if (sel_wr) begin
						state_q <= ecp_pkg::ECP_WRITE;
					end
				end
				ecp_pkg::ECP_READ: begin
					if (!sel_rd) begin
						state_q <= ecp_pkg::ECP_IDLE;
					end
				end
				ecp_pkg::ECP_WRITE: begin
					if (!sel_wr) begin
						state_q <= ecp_pkg::ECP_IDLE;
					end
				end
				default: begin
					state_q <= ecp_pkg::ECP_IDLE;
				end
			endcase
		end
	end

	// read capture; write data is dropped, nothing stored
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= `ECP_WORD_ZERO;
			hit_q <= 1'h0;
		end else if (state_q == ecp_pkg::ECP_IDLE && sel_rd) begin
			rdata_q <= rom_word;
			hit_q <= rom_hit;
		end
	end

	// constant words for neighbouring logic, reloaded every cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			struct_q <= `ECP_STRUCT_WORD;
			cap_q <= `ECP_CAP_WORD;
		end else begin
			struct_q <= `ECP_STRUCT_WORD;
			cap_q <= `ECP_CAP_WORD;
		end
	end

	// frame list size field in the command register may shrink lists
	always_ff @(posedge mclk) begin
		if (rst) begin
			programmable_frame_list_flag_q <= `ECP_PROGRAMMABLE_FRAME_LIST_FLAG_VAL;
		end else begin
			programmable_frame_list_flag_q <= cap_q[`ECP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT];
		end
	end

	// drive the data pins only for our own addresses
	assign data_oe = (state_q == ecp_pkg::ECP_READ) && hit_q;
	assign data_out = rdata_q;
	assign structural_parameters = struct_q;
	assign capability_parameters = cap_q;
	assign programmable_frame_list_flag = programmable_frame_list_flag_q;

	// checks
	AST_STRUCT_WORD:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters == `ECP_STRUCT_WORD)
	else $error("structural parameters word changed");

	AST_NPORTS:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_NPORTS_MSB:`ECP_NPORTS_LSB] == `ECP_NPORTS_VAL)
	else $error("port count not one");

	AST_PPC:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_PPC_BIT] == `ECP_PPC_VAL)
	else $error("port power control bit not set");

	AST_COMPANION:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_NCC_MSB:`ECP_NCC_LSB] == `ECP_NCC_VAL
		&& structural_parameters[`ECP_NPCC_MSB:`ECP_NPCC_LSB] == `ECP_NPCC_VAL)
	else $error("companion counts not zero");

	AST_ROUTING:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_PRR_BIT] == `ECP_PRR_VAL)
	else $error("port routing bit not zero");

	AST_DEBUG_PORT:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_DPN_MSB:`ECP_DPN_LSB] == `ECP_DPN_VAL)
	else $error("debug port number not zero");

	AST_INDICATOR:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_PIND_BIT] == `ECP_PIND_VAL)
	else $error("port indicator bit not zero");

	AST_RESERVED:
	assert property (@(posedge mclk) disable iff (rst)
		structural_parameters[`ECP_SRSVD_HI_MSB:`ECP_SRSVD_HI_LSB] == `ECP_SRSVD_HI_VAL
		&& structural_parameters[`ECP_SRSVD_MID_MSB:`ECP_SRSVD_MID_LSB] == `ECP_SRSVD_MID_VAL
		&& structural_parameters[`ECP_SRSVD_LO_MSB:`ECP_SRSVD_LO_LSB] == `ECP_SRSVD_LO_VAL
		&& capability_parameters[`ECP_CRSVD_HI_MSB:`ECP_CRSVD_HI_LSB] == `ECP_CRSVD_HI_VAL
		&& capability_parameters[`ECP_CRSVD_B3_BIT] == `ECP_CRSVD_B3_VAL
		&& capability_parameters[`ECP_CRSVD_B0_BIT] == `ECP_CRSVD_B0_VAL)
	else $error("reserved bits not zero");

	AST_CAP_WORD:
	assert property (@(posedge mclk) disable iff (rst)
		capability_parameters == `ECP_CAP_WORD)
	else $error("capability parameters word changed");

	AST_EXT_POINTER:
	assert property (@(posedge mclk) disable iff (rst)
		capability_parameters[`ECP_EECP_MSB:`ECP_EECP_LSB] == `ECP_EECP_VAL)
	else $error("extended capability pointer not zero");

	AST_ISO_THRESHOLD:
	assert property (@(posedge mclk) disable iff (rst)
		capability_parameters[`ECP_IST_MSB:`ECP_IST_LSB] == `ECP_IST_VAL)
	else $error("isochronous threshold not 1000b");

	AST_ASYNC_PARK:
	assert property (@(posedge mclk) disable iff (rst)
		capability_parameters[`ECP_ASYNC_PARK_CAPABILITY_BIT] == `ECP_ASYNC_PARK_CAPABILITY_VAL)
	else $error("async park bit not set");

	AST_PFL_FLAG:
	assert property (@(posedge mclk) disable iff (rst)
		capability_parameters[`ECP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT] == `ECP_PROGRAMMABLE_FRAME_LIST_FLAG_VAL)
	else $error("programmable frame list bit not set");

	AST_FLS_ENABLE:
	assert property (@(posedge mclk) disable iff (rst)
		programmable_frame_list_flag == $past(capability_parameters[`ECP_PROGRAMMABLE_FRAME_LIST_FLAG_BIT]))
	else $error("frame list flag output does not follow capability bit");

	AST_READ_STRUCT:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && sel_rd && {addr, 1'h0} == `ECP_STRUCT_OFFSET)
		|=> data_oe && data_out == `ECP_STRUCT_WORD)
	else $error("structural read returned wrong data");

	AST_READ_CAP:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && sel_rd && {addr, 1'h0} == `ECP_CAP_OFFSET)
		|=> data_oe && data_out == `ECP_CAP_WORD)
	else $error("capability read returned wrong data");

	AST_WRITE_IGNORED:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_WRITE)
		|=> !data_oe && $stable(data_out) && structural_parameters == `ECP_STRUCT_WORD
		&& capability_parameters == `ECP_CAP_WORD)
	else $error("write had a side effect");

	AST_READ_RELEASE:
	assert property (@(posedge mclk) disable iff (rst)
		(data_oe && !sel_rd) |=> !data_oe)
	else $error("data pins still driven after read strobe released");

	AST_STRUCT_STABLE:
	assert property (@(posedge mclk) disable iff (rst)
		$stable(structural_parameters))
	else $error("structural parameters word moved");

	AST_CAP_STABLE:
	assert property (@(posedge mclk) disable iff (rst)
		$stable(capability_parameters))
	else $error("capability parameters word moved");

	AST_FLAG_VALUE:
	assert property (@(posedge mclk) disable iff (rst)
		programmable_frame_list_flag == `ECP_PROGRAMMABLE_FRAME_LIST_FLAG_VAL)
	else $error("frame list flag output not set");

	AST_STATE_ONEHOT:
	assert property (@(posedge mclk) disable iff (rst)
		$onehot(state_q))
	else $error("bus cycle state not one-hot");

	AST_READ_TAKEN:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && sel_rd)
		|=> state_q == ecp_pkg::ECP_READ)
	else $error("read strobe not taken");

	AST_READ_WINS:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && sel_rd && sel_wr)
		|=> state_q == ecp_pkg::ECP_READ)
	else $error("write beat read with both strobes low");

	AST_WRITE_TAKEN:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && !sel_rd && sel_wr)
		|=> state_q == ecp_pkg::ECP_WRITE && !data_oe)
	else $error("write strobe not taken quietly");

	AST_WRITE_END:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_WRITE && !sel_wr)
		|=> state_q == ecp_pkg::ECP_IDLE)
	else $error("write cycle did not end");

	AST_READ_END:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_READ && !sel_rd)
		|=> state_q == ecp_pkg::ECP_IDLE)
	else $error("read cycle did not end");

	AST_UNMAPPED_QUIET:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_IDLE && sel_rd
		&& {addr, 1'h0} != `ECP_STRUCT_OFFSET && {addr, 1'h0} != `ECP_CAP_OFFSET)
		|=> !data_oe)
	else $error("data pins driven for a foreign address");

	AST_DATA_HOLD:
	assert property (@(posedge mclk) disable iff (rst)
		(state_q == ecp_pkg::ECP_READ && sel_rd)
		|=> $stable(data_out))
	else $error("read data moved during a read cycle");

	AST_OE_ONLY_READ:
	assert property (@(posedge mclk) disable iff (rst)
		data_oe
		|-> state_q == ecp_pkg::ECP_READ)
	else $error("data pins driven outside a read cycle");
endmodule
`default_nettype wire

//--- bench/ecp_capability_params_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ecp_capability_params_tb;
	logic mclk;
	logic rst;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [17:1] addr;
	logic [31:0] data_in;
	logic [31:0] data_out;
	logic data_oe;
	logic [31:0] structural_parameters;
	logic [31:0] capability_parameters;
	logic programmable_frame_list_flag;
	logic [31:0] rd_data;
	logic rd_oe;
	logic [31:0] rd_lat;
	int mismatches = 0;
	int n_checks = 0;

	ecp_capability_params i_dut (
		.mclk(mclk),
		.rst(rst),
		.cs_n(cs_n),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.addr(addr),
		.data_in(data_in),
		.data_out(data_out),
		.data_oe(data_oe),
		.structural_parameters(structural_parameters),
		.capability_parameters(capability_parameters),
		.programmable_frame_list_flag(programmable_frame_list_flag)
	);

	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end

	task automatic end_sim();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one pin-level access, held for ten cycles whatever the answer, then released
	task automatic access(input logic [17:0] ba, input logic rd, input logic wr,
		input logic [31:0] wd);
		@(negedge mclk);
		addr = ba[17:1];
		data_in = wd;
		cs_n = 1'h0;
		rd_n = ~rd;
		wr_n = ~wr;
		rd_oe = 1'h0;
		rd_data = 32'hFFFF_FFFF;
		rd_lat = 32'h0000_0000;
		for (int i = 1; i <= 10; i++) begin
			@(negedge mclk);
			if (data_oe === 1'h1 && rd_oe === 1'h0) begin
				rd_oe = 1'h1;
				rd_data = data_out;
				rd_lat = i;
			end
		end
		cs_n = 1'h1;
		rd_n = 1'h1;
		wr_n = 1'h1;
		data_in = 32'h0000_0000;
		repeat (6) @(negedge mclk);
		chk("data_oe after release", 32'h0000_0000, {31'h0, data_oe});
	endtask

	task automatic t_const_outputs();
		chk("structural_parameters", 32'h0000_0011, structural_parameters);
		chk("capability_parameters", 32'h0000_0086, capability_parameters);
		chk("frame list flag", 32'h0000_0001, {31'h0, programmable_frame_list_flag});
	endtask

	task automatic t_read_struct();
		access(18'h0_0004, 1'h1, 1'h0, 32'h0000_0000);
		chk("struct oe", 32'h0000_0001, {31'h0, rd_oe});
		chk("struct latency", 32'h0000_0005, rd_lat);
		chk("struct word", 32'h0000_0011, rd_data);
		chk("port count", 32'h0000_0001, {28'h0, rd_data[3:0]});
		chk("power control", 32'h0000_0001, {31'h0, rd_data[4]});
		chk("companions", 32'h0000_0000, {24'h0, rd_data[15:8]});
		chk("routing", 32'h0000_0000, {31'h0, rd_data[7]});
		chk("debug port", 32'h0000_0000, {28'h0, rd_data[23:20]});
		chk("indicator", 32'h0000_0000, {31'h0, rd_data[16]});
		chk("struct reserved", 32'h0000_0000, rd_data & 32'hFF0E_0060);
	endtask

	task automatic t_read_cap(input logic wr);
		access(18'h0_0008, 1'h1, wr, 32'h0000_FFF6);
		chk("cap oe", 32'h0000_0001, {31'h0, rd_oe});
		chk("cap latency", 32'h0000_0005, rd_lat);
		chk("cap word", 32'h0000_0086, rd_data);
		chk("ext pointer", 32'h0000_0000, {24'h0, rd_data[15:8]});
		chk("iso threshold", 32'h0000_0008, {28'h0, rd_data[7:4]});
		chk("park", 32'h0000_0001, {31'h0, rd_data[2]});
		chk("frame list bit", 32'h0000_0001, {31'h0, rd_data[1]});
		chk("cap reserved", 32'h0000_0000, rd_data & 32'hFFFF_0009);
	endtask

	task automatic t_writes_ignored();
		access(18'h0_0004, 1'h0, 1'h1, 32'h00F1_FF9F);
		chk("write oe", 32'h0000_0000, {31'h0, rd_oe});
		access(18'h0_0008, 1'h0, 1'h1, 32'h0000_FFF6);
		chk("write oe", 32'h0000_0000, {31'h0, rd_oe});
		t_const_outputs();
		t_read_struct();
		t_read_cap(1'h0);
	endtask

	task automatic t_unmapped();
		logic [17:0] list [3];
		list = '{18'h0_0000, 18'h0_000C, 18'h0_0020};
		foreach (list[i]) begin
			access(list[i], 1'h1, 1'h0, 32'h0000_0000);
			chk("unmapped oe", 32'h0000_0000, {31'h0, rd_oe});
		end
	endtask

	initial begin
		#8000;
		mismatches++;
		end_sim();
	end

	initial begin
		rst = 1'h1;
		cs_n = 1'h1;
		rd_n = 1'h1;
		wr_n = 1'h1;
		addr = 17'h0_0000;
		data_in = 32'h0000_0000;
		repeat (4) @(negedge mclk);
		rst = 1'h0;
		@(negedge mclk);
		chk("data_out at reset", 32'h0000_0000, data_out);
		chk("data_oe at reset", 32'h0000_0000, {31'h0, data_oe});
		t_const_outputs();
		t_read_struct();
		t_read_cap(1'h0);
		t_writes_ignored();
		t_unmapped();
		t_read_cap(1'h1);
		t_const_outputs();
		end_sim();
	end
endmodule
`default_nettype wire
